// file: rtl/teu_pkg.sv
// package for the timer event unit: register offsets, fields, reset values
package teu_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL0_OFS = 8'h00;
    localparam logic [7:0] CTRL1_OFS = 8'h04;
    localparam logic [7:0] IOC1_OFS = 8'h08;
    localparam logic [7:0] IOC2_OFS = 8'h0C;
    localparam logic [7:0] CMP0_OFS = 8'h10;
    localparam logic [7:0] CMP1_OFS = 8'h14;
    localparam logic [7:0] CNT_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1C;
    localparam logic [7:0] MASK_OFS = 8'h20;
    // ctrl0 field positions
    localparam int CE_POS = 0;
    // ctrl1 field positions
    localparam int MD_LSB = 0;
    localparam int EEE_POS = 5;
    localparam int RESTR_POS = 6;
    // io control fields
    localparam int IS_LSB = 0;
    localparam int EES_LSB = 0;
    // reset values
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [1:0] IRQ_MASK_RST = 2'h3;
    // modes
    typedef enum logic [2:0] {
        TEU_MD_INTERVAL = 3'h0,
        TEU_MD_EXT_EVENT = 3'h1,
        TEU_MD_EXT_TRIG = 3'h2,
        TEU_MD_ONE_SHOT = 3'h3
    } teu_mode_t;
    // edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// file: rtl/teu_top.sv
// timer event unit: 16-bit timer/event counter with an AXI4-Lite register slave
// Function
// - external count events come only from pin0
// - stop counting before lowering compare zero; not enforced here, a running count above it runs on and wraps past FFFF
// - no timer output in event count mode
// - interval mode with external enable counts events
// - mode field selects the operating mode
// - event edge select valid only when enabled
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module teu_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic capture_input_pin_0_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic timer_output_1_o,
    output logic irq_o
);
    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic count_enable;
        logic [2:0] mode;
        logic external_event_enable;
        logic restricted;
        logic [1:0] capture_edge_select;
        logic [1:0] event_edge_select;
        logic [15:0] compare_reg_0;
        logic [15:0] compare_reg_1;
        logic [15:0] count;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic tout1;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } teu_state_t;

    teu_state_t state_q;
    teu_state_t state_d;

    // register address decode, shared by the read and write paths
    function automatic logic teu_addr_ok(input logic [7:0] addr);
        case (addr)
            teu_pkg::CTRL0_OFS, teu_pkg::CTRL1_OFS, teu_pkg::IOC1_OFS, teu_pkg::IOC2_OFS,
            teu_pkg::CMP0_OFS, teu_pkg::CMP1_OFS, teu_pkg::CNT_OFS, teu_pkg::STAT_OFS,
            teu_pkg::MASK_OFS: teu_addr_ok = 1'b1;
            default: teu_addr_ok = 1'b0;
        endcase
    endfunction

    // edge detect per selected edge code
    function automatic logic teu_edge(input logic [1:0] sel, input logic prev, input logic cur);
        case (sel)
            teu_pkg::EDGE_RISE: teu_edge = cur & ~prev;
            teu_pkg::EDGE_FALL: teu_edge = prev & ~cur;
            teu_pkg::EDGE_BOTH: teu_edge = cur ^ prev;
            default: teu_edge = 1'b0;
        endcase
    endfunction

    // pin-clocked mode decode, shared by the clock select and the output gate
    function automatic logic teu_event_mode(input logic [2:0] mode);
        teu_event_mode = (mode == teu_pkg::TEU_MD_EXT_EVENT);
    endfunction

    logic ext_sel;
    logic ext_event;
    logic count_tick;
    logic at_cmp0;
    logic at_cmp1;
    logic wr_fire;
    logic rd_fire;

    // one state vector, filled here and registered below
    always_comb begin
        state_d = state_q;
        // pin synchroniser; only stage two and later feed logic
        state_d.pin_s1 = capture_input_pin_0_i;
        state_d.pin_s2 = state_q.pin_s1;
        state_d.pin_s3 = state_q.pin_s2;
        // mode 001 takes the pin as clock
        ext_sel = state_q.external_event_enable || teu_event_mode(state_q.mode);
        ext_event = ext_sel && teu_edge(state_q.event_edge_select, state_q.pin_s3, state_q.pin_s2);
        count_tick = state_q.count_enable && (ext_sel ? ext_event : 1'b1);
        at_cmp0 = (state_q.count == state_q.compare_reg_0);
        at_cmp1 = (state_q.count == state_q.compare_reg_1);
        // stopping clears the count, so every restart begins from zero
        // clear after compare zero match
        if (!state_q.count_enable) begin
            state_d.count = teu_pkg::CNT_RST;
        end else if (count_tick) begin
            // wraps if compare lowered below count
            state_d.count = at_cmp0 ? 16'h0000 : state_q.count + 16'h0001;
        end
        // match events set sticky status; set wins over clear
        if (count_tick && at_cmp0) begin
            state_d.irq_status[0] = 1'b1;
        end
        if (count_tick && at_cmp1) begin
            state_d.irq_status[1] = 1'b1;
        end
        // no output in event count mode
        if (!state_q.count_enable || teu_event_mode(state_q.mode)) begin
            state_d.tout1 = 1'b0;
        end else if (count_tick && at_cmp1) begin
            state_d.tout1 = ~state_q.tout1;
        end
        // pulse modes 010 and 011 count like interval; no pulse shaping is built
        // axi write channels are taken independently
        if (s_axi_awvalid_i && !state_q.aw_held) begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !state_q.w_held) begin
            state_d.w_held = 1'b1;
            state_d.w_data = s_axi_wdata_i;
            state_d.w_strb = s_axi_wstrb_i;
        end
        wr_fire = state_q.aw_held && state_q.w_held && !state_q.bvalid;
        if (wr_fire) begin
            state_d.aw_held = 1'b0;
            state_d.w_held = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp = teu_addr_ok(state_q.aw_addr) ? 2'h0 : 2'h2;
            case (state_q.aw_addr)
                teu_pkg::CTRL0_OFS: if (state_q.w_strb[0]) state_d.count_enable = state_q.w_data[teu_pkg::CE_POS];
                teu_pkg::CTRL1_OFS: if (state_q.w_strb[0]) begin
                    state_d.mode = state_q.w_data[teu_pkg::MD_LSB +: 3];
                    state_d.external_event_enable = state_q.w_data[teu_pkg::EEE_POS];
                    state_d.restricted = state_q.w_data[teu_pkg::RESTR_POS];
                end
                teu_pkg::IOC1_OFS: if (state_q.w_strb[0]) state_d.capture_edge_select = state_q.w_data[teu_pkg::IS_LSB +: 2];
                teu_pkg::IOC2_OFS: if (state_q.w_strb[0]) state_d.event_edge_select = state_q.w_data[teu_pkg::EES_LSB +: 2];
                teu_pkg::CMP0_OFS: begin
                    if (state_q.w_strb[0]) state_d.compare_reg_0[7:0] = state_q.w_data[7:0];
                    if (state_q.w_strb[1]) state_d.compare_reg_0[15:8] = state_q.w_data[15:8];
                end
                teu_pkg::CMP1_OFS: begin
                    if (state_q.w_strb[0]) state_d.compare_reg_1[7:0] = state_q.w_data[7:0];
                    if (state_q.w_strb[1]) state_d.compare_reg_1[15:8] = state_q.w_data[15:8];
                end
                teu_pkg::STAT_OFS: if (state_q.w_strb[0]) begin
                    // write one clears, but a same-cycle match keeps its bit
                    state_d.irq_status = state_q.irq_status & ~state_q.w_data[1:0];
                    if (count_tick && at_cmp0) state_d.irq_status[0] = 1'b1;
                    if (count_tick && at_cmp1) state_d.irq_status[1] = 1'b1;
                end
                teu_pkg::MASK_OFS: if (state_q.w_strb[0]) state_d.irq_mask = state_q.w_data[1:0];
                default: ;
            endcase
        end
        if (state_q.bvalid && s_axi_bready_i) begin
            state_d.bvalid = 1'b0;
        end
        // read path: one cycle after address is taken
        rd_fire = s_axi_arvalid_i && !state_q.rvalid;
        if (rd_fire) begin
            state_d.rvalid = 1'b1;
            state_d.rresp = teu_addr_ok(s_axi_araddr_i) ? 2'h0 : 2'h2;
            case (s_axi_araddr_i)
                teu_pkg::CTRL0_OFS: state_d.rdata = {31'h0000_0000, state_q.count_enable};
                teu_pkg::CTRL1_OFS: state_d.rdata = {25'h000_0000, state_q.restricted,
                    state_q.external_event_enable, 2'h0, state_q.mode};
                teu_pkg::IOC1_OFS: state_d.rdata = {30'h0000_0000, state_q.capture_edge_select};
                teu_pkg::IOC2_OFS: state_d.rdata = {30'h0000_0000, state_q.event_edge_select};
                teu_pkg::CMP0_OFS: state_d.rdata = {16'h0000, state_q.compare_reg_0};
                teu_pkg::CMP1_OFS: state_d.rdata = {16'h0000, state_q.compare_reg_1};
                teu_pkg::CNT_OFS: state_d.rdata = {16'h0000, state_q.count};
                teu_pkg::STAT_OFS: state_d.rdata = {30'h0000_0000, state_q.irq_status};
                teu_pkg::MASK_OFS: state_d.rdata = {30'h0000_0000, state_q.irq_mask};
                default: state_d.rdata = 32'h0000_0000;
            endcase
        end
        if (state_q.rvalid && s_axi_rready_i) begin
            state_d.rvalid = 1'b0;
        end
    end

    // state register; constants only under reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= '0;
            state_q.compare_reg_0 <= teu_pkg::CMP_RST;
            state_q.compare_reg_1 <= teu_pkg::CMP_RST;
            state_q.count <= teu_pkg::CNT_RST;
            state_q.irq_mask <= teu_pkg::IRQ_MASK_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ready outputs are combinational, valid and data from flops
    assign s_axi_awready_o = !state_q.aw_held;
    assign s_axi_wready_o = !state_q.w_held;
    assign s_axi_bvalid_o = state_q.bvalid;
    assign s_axi_bresp_o = state_q.bresp;
    assign s_axi_arready_o = !state_q.rvalid;
    assign s_axi_rvalid_o = state_q.rvalid;
    assign s_axi_rdata_o = state_q.rdata;
    assign s_axi_rresp_o = state_q.rresp;
    assign timer_output_1_o = state_q.tout1;
    // level interrupt while any unmasked status bit is set
    assign irq_o = |(state_q.irq_status & ~state_q.irq_mask);

    // checks sit beside the logic; all of them rest while reset is high

    AST_EVENT_MODE_NO_OUTPUT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q.mode == teu_pkg::TEU_MD_EXT_EVENT) |=> !timer_output_1_o)
        else $error("timer output active in event count mode");

    AST_CMP0_WRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (count_tick && at_cmp0 && state_q.count_enable) |=> (state_q.count == 16'h0000 && state_q.irq_status[0]))
        else $error("counter did not clear after compare match");

    AST_EXT_ONLY_PIN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ext_sel && state_q.count_enable && !ext_event && !wr_fire) |=> $stable(state_q.count))
        else $error("counter moved without pin event");

    AST_INTERNAL_TICK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!ext_sel && state_q.count_enable && !at_cmp0) |=> (state_q.count == $past(state_q.count) + 16'h0001))
        else $error("internal clock did not advance counter");

    AST_EDGE_GATED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q.external_event_enable && state_q.count_enable
            && state_q.event_edge_select == teu_pkg::EDGE_RISE && state_q.pin_s2 && !state_q.pin_s3 && !at_cmp0)
            |=> (state_q.count == $past(state_q.count) + 16'h0001))
        else $error("selected pin edge did not advance counter");

    AST_MODE_DECODE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q.mode == teu_pkg::TEU_MD_EXT_EVENT && state_q.count_enable && state_q.pin_s2 == state_q.pin_s3)
            |=> $stable(state_q.count))
        else $error("event count mode moved without a pin edge");

    AST_OVERFLOW_WRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (count_tick && state_q.count == 16'hFFFF && !at_cmp0) |=> state_q.count == 16'h0000)
        else $error("counter overflow did not wrap");

    AST_IRQ_LEVEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (count_tick && at_cmp0 && !state_q.irq_mask[0] && !wr_fire) |=> irq_o)
        else $error("unmasked match did not raise interrupt");

    AST_DISABLE_CLEARS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !state_q.count_enable |=> (state_q.count == teu_pkg::CNT_RST))
        else $error("stopped counter not cleared");

    AST_TOUT_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (count_tick && at_cmp1 && state_q.mode != teu_pkg::TEU_MD_EXT_EVENT)
            |=> (timer_output_1_o != $past(timer_output_1_o)))
        else $error("timer output missed a compare one match");

    AST_STATUS_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (count_tick && at_cmp1) |=> state_q.irq_status[1])
        else $error("compare one match not recorded");

    // write answered the edge after both halves are held
    AST_WRITE_ANSWER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q.aw_held && state_q.w_held && !state_q.bvalid) |=> s_axi_bvalid_o)
        else $error("write not answered");

    // read answered the edge after the address is taken
    AST_READ_ANSWER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o)
        else $error("read not answered");
endmodule

// file: dv/teu_pin_model.sv
// external event source that drives capture input pin 0
`timescale 1ns/1ps
module teu_pin_model (
    input wire logic ref_clk_i,
    output logic pin_o
);
    // idle low between bursts so no stray edge is counted
    initial pin_o = 1'b0;
    // events on pin0
    // width w in cycles, kept at two or more so the two-flop sync sees every level
    task automatic burst(input int k, input int w);
        repeat (k) begin
            repeat (w) @(posedge ref_clk_i);
            pin_o <= 1'b1;
            repeat (w) @(posedge ref_clk_i);
            pin_o <= 1'b0;
        end
    endtask
endmodule

// file: dv/timer_event_counter_modes_tb.sv
// self-checking bench for the timer event unit
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h want %h", $time, a, e); end end
module timer_event_counter_modes_tb;
    logic clk = 1'b0, rst = 1'b1, pin, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awrdy, wrdy, bv, arrdy, rv, tout, irq, tlast = 1'b0;
    logic [1:0] bresp, rresp;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdata;
    logic [15:0] s = 16'h001a;
    int errors = 0, tests_run = 0, cyc = 0, ntog = 0;
    time tnow = 0, tprev = 0;

    always #25 clk = ~clk;

    teu_top u_dut (.ref_clk_i(clk), .rst_i(rst), .capture_input_pin_0_i(pin),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .timer_output_1_o(tout), .irq_o(irq));

    teu_pin_model u_pin (.ref_clk_i(clk), .pin_o(pin));

    // toggle times kept, so a period is read from times and not from process order
    always @(negedge clk) begin
        if (tout !== tlast) begin
            tprev = tnow;
            tnow = $time;
            ntog++;
        end
        tlast = tout;
    end

    // hang guard, above the roughly 67000 cycles the run needs with the long wrap wait
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic int per(input int n);
        return n + 1;
    endfunction

    function automatic int evts(input int e, input int k);
        return (e == 3) ? 2 * k : k;
    endfunction

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awv && awrdy;
            tw = wv && wrdy;
            tb = bv;
            r = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        br <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = arv && arrdy;
            tr = rv;
            v = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end
        rr <= 1'b0;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n, k, c;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(teu_pkg::MASK_OFS, d, r);
        `CHK(d[1:0], teu_pkg::IRQ_MASK_RST)
        // unmapped place answers with an error
        rd(8'h24, d, r);
        `CHK({r, d}, {2'h2, 32'h0000_0000})
        wr(8'h24, 32'h0000_0000, r);
        `CHK(r, 2'h2)
        for (int m = 0; m < 4; m++) begin
            wr(teu_pkg::CTRL1_OFS, 32'(m), r);
            rd(teu_pkg::CTRL1_OFS, d, r);
            `CHK(d[2:0], 3'(m))
        end
        wr(teu_pkg::CTRL1_OFS, 32'h0, r);
        for (int i = 0; i < 3; i++) begin
            s = nx(s);
            n = 3 + s[3:0];
            wr(teu_pkg::CTRL0_OFS, 32'h0, r);
            wr(teu_pkg::CMP0_OFS, 32'(n), r);
            wr(teu_pkg::CMP1_OFS, 32'h1, r);
            wr(teu_pkg::CTRL0_OFS, 32'h1, r);
            c = ntog;
            while (ntog < c + 3) @(negedge clk);
            `CHK(tnow - tprev, time'(50 * per(n)))
        end
        wr(teu_pkg::MASK_OFS, 32'h2, r);
        repeat (40) @(negedge clk);
        `CHK(irq, 1'b1)
        wr(teu_pkg::MASK_OFS, 32'h3, r);
        `CHK(irq, 1'b0)
        wr(teu_pkg::CTRL0_OFS, 32'h0, r);
        rd(teu_pkg::STAT_OFS, d, r);
        `CHK(d[0], 1'b1)
        wr(teu_pkg::STAT_OFS, 32'h1, r);
        wr(teu_pkg::MASK_OFS, 32'h2, r);
        rd(teu_pkg::STAT_OFS, d, r);
        `CHK({d[0], irq}, 2'h0)
        wr(teu_pkg::IOC1_OFS, 32'h0, r);
        wr(teu_pkg::CMP0_OFS, 32'h00ff, r);
        for (int e = 1; e < 5; e++) begin
            s = nx(s);
            k = 2 + s[2:0];
            wr(teu_pkg::CTRL0_OFS, 32'h0, r);
            wr(teu_pkg::IOC2_OFS, 32'(e > 3 ? 3 : e), r);
            wr(teu_pkg::CTRL1_OFS, e > 3 ? 32'h1 : 32'h20, r);
            wr(teu_pkg::CTRL0_OFS, 32'h1, r);
            c = ntog;
            u_pin.burst(k, 2 + s[5:4]);
            repeat (8) @(negedge clk);
            rd(teu_pkg::CNT_OFS, d, r);
            `CHK(d[15:0], 16'(evts(e > 3 ? 3 : e, k)))
            if (e > 3) `CHK(ntog, c)
        end
        // compare zero lowered mid-count: counter runs past it and wraps
        wr(teu_pkg::CTRL0_OFS, 32'h0, r);
        wr(teu_pkg::CTRL1_OFS, 32'h0, r);
        wr(teu_pkg::CMP0_OFS, 32'h0100, r);
        wr(teu_pkg::CTRL0_OFS, 32'h1, r);
        repeat (200) @(negedge clk);
        wr(teu_pkg::CMP0_OFS, 32'h0040, r);
        wr(teu_pkg::STAT_OFS, 32'h3, r);
        repeat (60000) @(negedge clk);
        rd(teu_pkg::STAT_OFS, d, r);
        `CHK(d[0], 1'b0)
        repeat (6000) @(negedge clk);
        rd(teu_pkg::STAT_OFS, d, r);
        `CHK(d[0], 1'b1)
        print_verdict();
    end
endmodule
